// ===== rtl/ict_timing.sv
`timescale 1ns/100ps
// How it works
// (RULE_01) conditional jumps: 3 not taken, 5 taken
// (RULE_02) counted loops: 3 exit, 4 taken
// (RULE_03) accumulator to memory: 5, narrow 8/12
// (RULE_04) memory to accumulator: 5, narrow 8/12
// (RULE_05) immediate to register: one clock
// (RULE_06) repeated string load: 8+8n, narrow 12+12n
// (RULE_07) repeated string copy: 24+24n, narrow 32+32n
// (RULE_08) repeated port write: 8+8n, narrow 12/20 based
// (RULE_09) repeated compare: 11+8n, narrow 8/12 based
// (RULE_10) return adding to stack: 16, narrow 13
// (RULE_11) rotate left by one: 1, memory 8/16
// (RULE_12) rotate left by count register: 1, 8/16
// (RULE_13) rotate right by one: 1, memory 8/16
// (RULE_14) rotate right by count register: 1, 8/16
// (RULE_15) immediate disjunction into accumulator: one clock
// (RULE_16) shift left by one: 5, narrow 1/32
// (RULE_17) table lookup, countdown, done at expiry
module ict_timing #(
    parameter int unsigned CNT_W = ict_pkg::ICT_CNT_W
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              issue_valid,
    output logic                   issue_ready,
    input  wire ict_pkg::ict_req_t issue_req,
    output logic                   busy,
    output logic                   done,
    output logic [CNT_W-1:0]       total_clocks
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // refuse a counter too narrow for base plus n times cost
    if (CNT_W < ict_pkg::ICT_REP_W + 8) begin : g_bad_cnt_w
        $error("ict_timing: CNT_W cannot hold base plus n times cost");
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef enum {
        ICT_ST_IDLE,
        ICT_ST_RUN
    } ict_phase_t;

    typedef struct packed {
        ict_phase_t       phase;  // idle or running
        logic             done;   // completion pulse
        logic [CNT_W-1:0] total;  // clocks of the current instruction
    } ict_state_t;

    ict_state_t         st;        // registered state
    ict_state_t         next_st;   // next state
    ict_pkg::ict_cost_t cost;      // looked-up cost
    logic [CNT_W-1:0]   req_total; // total clocks for the request
    logic               load;      // start the countdown
    logic               last;      // counter in its final clock

    // ************************************************************
    // lookup and total
    // ************************************************************
    ict_cost_table u_table (
        .req  (issue_req),
        .cost (cost)
    ); // RULE_17

    // total = base + n * per_rep when repeated, else base
    always_comb begin
        req_total = CNT_W'(cost.base);
        if (issue_req.repeat_en) begin
            req_total = CNT_W'(cost.base) + CNT_W'(cost.per_rep) * CNT_W'(issue_req.rep_n); // RULE_06
        end
    end

    assign issue_ready = (st.phase == ICT_ST_IDLE);
    assign load        = issue_valid && issue_ready;

    // ************************************************************
    // countdown
    // ************************************************************
    ict_down_counter #(
        .WIDTH (CNT_W)
    ) u_count (
        .clk      (clk),
        .rst_b    (rst_b),
        .load     (load),
        .load_val (req_total),
        .count    (),
        .last     (last)
    );

    // phase control and completion
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        case (st.phase)
            ICT_ST_IDLE: begin
                if (load) begin
                    next_st.phase = ICT_ST_RUN;
                    next_st.total = req_total;
                end
            end
            ICT_ST_RUN: begin
                if (last) begin
                    next_st.phase = ICT_ST_IDLE; // RULE_17
                    next_st.done  = 1'b1;
                end
            end
            default: begin
                next_st.phase = ICT_ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= '{phase: ICT_ST_IDLE, done: 1'b0, total: '0};
        end else begin
            st <= next_st;
        end
    end

    assign busy         = (st.phase == ICT_ST_RUN);
    assign done         = st.done;
    assign total_clocks = st.total;

endmodule // ict_timing

// ===== rtl/ict_pkg.sv
package ict_pkg;

    // ************************************************************
    // instruction classes handled by the timing block
    // ************************************************************
    typedef enum logic [4:0] {
        ICT_OP_JUMP_IF_NOT_SIGN,
        ICT_OP_JUMP_IF_NONZERO,
        ICT_OP_JUMP_IF_OVERFLOW,
        ICT_OP_JUMP_IF_PARITY,
        ICT_OP_JUMP_IF_PARITY_EVEN,
        ICT_OP_JUMP_IF_PARITY_ODD,
        ICT_OP_JUMP_IF_SIGN,
        ICT_OP_JUMP_IF_ZERO,
        ICT_OP_DECREMENT_BRANCH,
        ICT_OP_DECREMENT_BRANCH_IF_EQUAL,
        ICT_OP_DECREMENT_BRANCH_IF_UNEQUAL,
        ICT_OP_DECREMENT_BRANCH_IF_NONZERO,
        ICT_OP_DECREMENT_BRANCH_IF_ZERO,
        ICT_OP_COPY_ACCUM_TO_MEM,
        ICT_OP_COPY_MEM_TO_ACCUM,
        ICT_OP_COPY_IMM_TO_REG,
        ICT_OP_STRING_LOAD,
        ICT_OP_STRING_COPY,
        ICT_OP_STRING_PORT_WRITE,
        ICT_OP_STRING_COMPARE_ACCUM,
        ICT_OP_SUBROUTINE_EXIT_ADD_SP,
        ICT_OP_ROTATE_LEFT_ONE,
        ICT_OP_ROTATE_LEFT_BY_COUNT_REG,
        ICT_OP_ROTATE_RIGHT_ONE,
        ICT_OP_ROTATE_RIGHT_BY_COUNT_REG,
        ICT_OP_DISJUNCTION_IMM_ACCUM,
        ICT_OP_SHIFT_LEFT_ONE
    } ict_op_t;

    // ************************************************************
    // widths and constants
    // ************************************************************
    localparam int unsigned ICT_CNT_W     = 24;
    localparam int unsigned ICT_REP_W     = 16;
    localparam int unsigned ICT_CLK_MHZ   = 50;

    localparam logic [7:0]  ICT_RST_COUNT = 8'h00;

    // one lookup result: fixed part plus per-repeat part
    typedef struct packed {
        logic [7:0] base;       // clocks spent once
        logic [7:0] per_rep;    // clocks added for each repetition
    } ict_cost_t;

    // one issue request
    typedef struct packed {
        ict_op_t              op;       // instruction class
        logic                 narrow;   // narrow-bus variant
        logic                 in_mem;   // operand in memory
        logic                 is_word;  // 16-bit operand
        logic                 taken;    // branch taken
        logic                 repeat_en;// repeat prefix given
        logic [ICT_REP_W-1:0] rep_n;    // repeat count
    } ict_req_t;

endpackage : ict_pkg

// ===== rtl/ict_cost_table.sv
`timescale 1ns/100ps
// ************************************************************
// per-opcode cost lookup, purely combinational
// ************************************************************
module ict_cost_table (
    input  wire ict_pkg::ict_req_t  req,
    output ict_pkg::ict_cost_t      cost
);

    // ************************************************************
    // choose between wide and narrow figures
    // ************************************************************
    function automatic logic [7:0] pick(input logic nar, input logic [7:0] w,
                                        input logic [7:0] n);
        pick = nar ? n : w;
    endfunction

    // table lookup
    always_comb begin
        cost = '{base: 8'h01, per_rep: 8'h00};
        case (req.op)
            ict_pkg::ICT_OP_JUMP_IF_NOT_SIGN,
            ict_pkg::ICT_OP_JUMP_IF_NONZERO,
            ict_pkg::ICT_OP_JUMP_IF_OVERFLOW,
            ict_pkg::ICT_OP_JUMP_IF_PARITY,
            ict_pkg::ICT_OP_JUMP_IF_PARITY_EVEN,
            ict_pkg::ICT_OP_JUMP_IF_PARITY_ODD,
            ict_pkg::ICT_OP_JUMP_IF_SIGN,
            ict_pkg::ICT_OP_JUMP_IF_ZERO: begin
                cost.base = req.taken ? 8'h05 : 8'h03; // RULE_01
            end
            ict_pkg::ICT_OP_DECREMENT_BRANCH,
            ict_pkg::ICT_OP_DECREMENT_BRANCH_IF_EQUAL,
            ict_pkg::ICT_OP_DECREMENT_BRANCH_IF_UNEQUAL,
            ict_pkg::ICT_OP_DECREMENT_BRANCH_IF_NONZERO,
            ict_pkg::ICT_OP_DECREMENT_BRANCH_IF_ZERO: begin
                cost.base = req.taken ? 8'h04 : 8'h03; // RULE_02
            end
            ict_pkg::ICT_OP_COPY_ACCUM_TO_MEM: begin
                cost.base = pick(req.narrow, 8'h05, req.is_word ? 8'h0C : 8'h08); // RULE_03
            end
            ict_pkg::ICT_OP_COPY_MEM_TO_ACCUM: begin
                cost.base = pick(req.narrow, 8'h05, req.is_word ? 8'h0C : 8'h08); // RULE_04
            end
            ict_pkg::ICT_OP_COPY_IMM_TO_REG: begin
                cost.base = 8'h01; // RULE_05
            end
            ict_pkg::ICT_OP_STRING_LOAD: begin
                cost.base    = pick(req.narrow, 8'h08, 8'h0C); // RULE_06
                cost.per_rep = cost.base; // RULE_06
            end
            ict_pkg::ICT_OP_STRING_COPY: begin
                cost.base    = pick(req.narrow, 8'h18, 8'h20); // RULE_07
                cost.per_rep = cost.base; // RULE_07
            end
            ict_pkg::ICT_OP_STRING_PORT_WRITE: begin
                cost.base    = pick(req.narrow, 8'h08, req.is_word ? 8'h14 : 8'h0C); // RULE_08
                cost.per_rep = cost.base; // RULE_08
            end
            ict_pkg::ICT_OP_STRING_COMPARE_ACCUM: begin
                cost.base    = pick(req.narrow, 8'h0B, req.is_word ? 8'h0C : 8'h08); // RULE_09
                cost.per_rep = pick(req.narrow, 8'h08, req.is_word ? 8'h0C : 8'h08); // RULE_09
            end
            ict_pkg::ICT_OP_SUBROUTINE_EXIT_ADD_SP: begin
                cost.base = pick(req.narrow, 8'h10, 8'h0D); // RULE_10
            end
            ict_pkg::ICT_OP_ROTATE_LEFT_ONE: begin
                cost.base = req.in_mem ? pick(req.narrow, 8'h08, 8'h10) : 8'h01; // RULE_11
            end
            ict_pkg::ICT_OP_ROTATE_LEFT_BY_COUNT_REG: begin
                cost.base = req.in_mem ? pick(req.narrow, 8'h08, 8'h10) : 8'h01; // RULE_12
            end
            ict_pkg::ICT_OP_ROTATE_RIGHT_ONE: begin
                cost.base = req.in_mem ? pick(req.narrow, 8'h08, 8'h10) : 8'h01; // RULE_13
            end
            ict_pkg::ICT_OP_ROTATE_RIGHT_BY_COUNT_REG: begin
                cost.base = req.in_mem ? pick(req.narrow, 8'h08, 8'h10) : 8'h01; // RULE_14
            end
            ict_pkg::ICT_OP_DISJUNCTION_IMM_ACCUM: begin
                cost.base = 8'h01; // RULE_15
            end
            ict_pkg::ICT_OP_SHIFT_LEFT_ONE: begin
                cost.base = pick(req.narrow, 8'h05, req.in_mem ? 8'h20 : 8'h01); // RULE_16
            end
            default: begin
                cost.base = 8'h01;
            end
        endcase
    end

endmodule // ict_cost_table

// ===== rtl/ict_down_counter.sv
`timescale 1ns/100ps
// ************************************************************
// loadable down counter, flags the last cycle
// ************************************************************
module ict_down_counter #(
    parameter int unsigned WIDTH = ict_pkg::ICT_CNT_W
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    output logic      [WIDTH-1:0] count,
    output logic                  last
);

    // refuse a width too small for the largest 8-bit base cost
    if (WIDTH < 8) begin : g_bad_width
        $error("ict_down_counter: WIDTH too small");
    end

    typedef struct packed {
        logic [WIDTH-1:0] cnt; // clocks still to run
    } ict_dc_state_t;

    ict_dc_state_t st;      // registered state
    ict_dc_state_t next_st; // next state

    // next value: load, else count down to zero
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.cnt = load_val;
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - WIDTH'(1);
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.cnt;
    assign last  = (st.cnt == WIDTH'(1));

endmodule // ict_down_counter

// ===== sim/ict_timing_assertions.sv
`timescale 1ns/100ps
// ****************************************
// port checker for the timing block
// ****************************************
module ict_timing_assertions #(
    parameter int unsigned CNT_W = ict_pkg::ICT_CNT_W
) (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              issue_valid,
    input wire logic              issue_ready,
    input wire ict_pkg::ict_req_t issue_req,
    input wire logic              busy,
    input wire logic              done,
    input wire logic [CNT_W-1:0]  total_clocks
);
    logic              tk;  // request taken at this edge
    ict_pkg::ict_req_t rq;  // request seen one edge ago
    logic [CNT_W-1:0]  run; // busy cycles so far in this run
    assign tk = issue_valid && issue_ready;
    // busy run length, cleared when idle
    always_ff @(posedge clk) begin
        run <= (busy && rst_b) ? run + 1'h1 : '0;
        rq  <= issue_req;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_jump;
        tk && issue_req.op <= ict_pkg::ICT_OP_JUMP_IF_ZERO
            |=> total_clocks == (rq.taken ? 24'h5 : 24'h3);
    endproperty
    a_jump: assert property (p_jump) else $error("jump count wrong");
    property p_loop;
        tk && issue_req.op inside {[ict_pkg::ICT_OP_DECREMENT_BRANCH:
            ict_pkg::ICT_OP_DECREMENT_BRANCH_IF_ZERO]}
            |=> total_clocks == (rq.taken ? 24'h4 : 24'h3);
    endproperty
    a_loop: assert property (p_loop) else $error("loop count wrong");
    property p_copy;
        tk && issue_req.op inside {ict_pkg::ICT_OP_COPY_ACCUM_TO_MEM,
            ict_pkg::ICT_OP_COPY_MEM_TO_ACCUM}
            |=> total_clocks == (!rq.narrow ? 24'h5 : rq.is_word ? 24'hC : 24'h8);
    endproperty
    a_copy: assert property (p_copy) else $error("copy count wrong");
    property p_one;
        tk && issue_req.op inside {ict_pkg::ICT_OP_COPY_IMM_TO_REG,
            ict_pkg::ICT_OP_DISJUNCTION_IMM_ACCUM} |=> total_clocks == 24'h1;
    endproperty
    a_one: assert property (p_one) else $error("one clock op wrong");
    property p_rot;
        tk && issue_req.op inside {[ict_pkg::ICT_OP_ROTATE_LEFT_ONE:
            ict_pkg::ICT_OP_ROTATE_RIGHT_BY_COUNT_REG]}
            |=> total_clocks == (!rq.in_mem ? 24'h1 : rq.narrow ? 24'h10 : 24'h8);
    endproperty
    a_rot: assert property (p_rot) else $error("rotate count wrong");
    property p_shift;
        tk && issue_req.op == ict_pkg::ICT_OP_SHIFT_LEFT_ONE
            |=> total_clocks == (!rq.narrow ? 24'h5 : rq.in_mem ? 24'h20 : 24'h1);
    endproperty
    a_shift: assert property (p_shift) else $error("shift count wrong");
    property p_long;
        busy |-> run < total_clocks && !issue_ready && !done;
    endproperty
    a_long: assert property (p_long) else $error("busy too long");
    property p_len;
        done |-> run == total_clocks && issue_ready && !busy ##1 !done;
    endproperty
    a_len: assert property (p_len) else $error("done at wrong time");
    c_btb: cover property (done && issue_valid);
    c_rep: cover property (tk && issue_req.repeat_en);
    c_ref: cover property (busy && issue_valid);
endmodule // ict_timing_assertions

bind ict_timing ict_timing_assertions #(.CNT_W(CNT_W)) ict_timing_assertions_i (
    .clk(clk), .rst_b(rst_b), .issue_valid(issue_valid), .issue_ready(issue_ready),
    .issue_req(issue_req), .busy(busy), .done(done), .total_clocks(total_clocks));

// ===== sim/ict_timing_tb.sv
`timescale 1ns/100ps
module ict_timing_tb;
    // ****************************************
    // signals and case table
    // ****************************************
    typedef struct packed {
        ict_pkg::ict_req_t req; // request sent
        logic [23:0]       exp; // expected clocks
    } ict_row_t;
    logic              clk = 1'h0;
    logic              rst_b = 1'h0;
    logic              issue_valid = 1'h0;
    logic              issue_ready;
    ict_pkg::ict_req_t issue_req = '0;
    logic              busy;
    logic              done;
    logic [23:0]       total_clocks;
    ict_row_t          rows [$]; // ordinary cases
    int                failures = 0;
    int                check_count = 0;
    // clock of 20 ns
    always #10 clk = ~clk;
    ict_timing ict_timing_i (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .issue_req(issue_req), .busy(busy), .done(done),
        .total_clocks(total_clocks));
    // compare and report
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request from op, flags {narrow,in_mem,is_word,taken,repeat_en} and count
    function automatic ict_pkg::ict_req_t mk(input logic [4:0] op, input logic [4:0] f,
                                             input logic [15:0] n);
        mk = '{ict_pkg::ict_op_t'(op), f[4], f[3], f[2], f[1], f[0], n};
    endfunction
    // table row: op, flags, count, clocks
    task automatic add(input logic [4:0] op, input logic [4:0] f,
                       input logic [15:0] n, input logic [23:0] e);
        rows.push_back('{mk(op, f, n), e});
    endtask
    // issue one request, optionally poke a refused one while busy
    task automatic run(input ict_row_t r, input bit poke);
        int n;
        n = 0;
        check(issue_ready, 24'h1);
        issue_valid = 1'h1;
        issue_req   = r.req;
        @(posedge clk) #1;
        while (done !== 1'h1 && n < 5000) begin
            if (busy === 1'h1) n++;
            issue_valid = poke && n == 2;
            issue_req.op = poke ? ict_pkg::ICT_OP_JUMP_IF_ZERO : r.req.op;
            @(posedge clk) #1;
        end
        check(total_clocks, r.exp);
        check(24'(n), r.exp);
    endtask
    // verdict
    task automatic end_of_test();
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        for (int i = 0; i < 13; i++) begin
            add(5'(i), {3'h0, i[0], 1'h0}, 16'h0,
                i < 8 ? (i[0] ? 24'h5 : 24'h3) : (i[0] ? 24'h4 : 24'h3));
        end
        add(5'h0D, 5'h00, 16'h0, 24'h05);
        add(5'h0D, 5'h10, 16'h0, 24'h08);
        add(5'h0E, 5'h14, 16'h0, 24'h0C);
        add(5'h0E, 5'h04, 16'h0, 24'h05);
        add(5'h0F, 5'h18, 16'h0, 24'h01);
        add(5'h10, 5'h01, 16'h3, 24'h20);
        add(5'h10, 5'h11, 16'h0, 24'h0C);
        add(5'h11, 5'h11, 16'h2, 24'h60);
        add(5'h11, 5'h00, 16'h5, 24'h18);
        add(5'h12, 5'h01, 16'h1, 24'h10);
        add(5'h12, 5'h11, 16'h2, 24'h24);
        add(5'h12, 5'h15, 16'h2, 24'h3C);
        add(5'h13, 5'h05, 16'h2, 24'h1B);
        add(5'h13, 5'h11, 16'h1, 24'h10);
        add(5'h13, 5'h15, 16'h1, 24'h18);
        add(5'h14, 5'h00, 16'h0, 24'h10);
        add(5'h14, 5'h10, 16'h0, 24'h0D);
        add(5'h15, 5'h10, 16'h0, 24'h01);
        add(5'h15, 5'h08, 16'h0, 24'h08);
        add(5'h16, 5'h18, 16'h0, 24'h10);
        add(5'h17, 5'h18, 16'h0, 24'h10);
        add(5'h18, 5'h00, 16'h0, 24'h01);
        add(5'h18, 5'h08, 16'h0, 24'h08);
        add(5'h19, 5'h08, 16'h0, 24'h01);
        add(5'h1A, 5'h08, 16'h0, 24'h05);
        add(5'h1A, 5'h10, 16'h0, 24'h01);
        add(5'h1A, 5'h18, 16'h0, 24'h20);
        repeat (20) @(posedge clk);
        #1 rst_b = 1'h1;
        foreach (rows[i]) run(rows[i], 1'b0);
        // request while busy must be ignored
        run('{mk(ict_pkg::ICT_OP_STRING_COPY, 5'h01, 16'h2), 24'h48}, 1'b1);
        // reset in mid-run clears busy, done and total_clocks and raises issue_ready
        issue_valid = 1'h1;
        issue_req   = mk(ict_pkg::ICT_OP_STRING_COPY, 5'h11, 16'h3);
        @(posedge clk) #1;
        issue_valid = 1'h0;
        repeat (4) @(posedge clk) #1;
        rst_b = 1'h0;
        @(posedge clk) #1;
        check({busy, done, issue_ready}, 24'h1);
        check(total_clocks, 24'h0);
        rst_b = 1'h1;
        run('{mk(ict_pkg::ICT_OP_JUMP_IF_ZERO, 5'h02, 16'h0), 24'h5}, 1'b0);
        end_of_test();
    end
endmodule // ict_timing_tb
